// File: stg_params.svh
// Register offsets, field positions, reset values and sizes of the spanning tree port gate.
`ifndef STG_PARAMS_SVH
`define STG_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define STG_PORT1_CTRL_ADDR 8'h12
`define STG_PORT2_CTRL_ADDR 8'h22
`define STG_PORT3_CTRL_ADDR 8'h32
`define STG_PORT4_CTRL_ADDR 8'h42
`define STG_GLOBAL_CTRL_ADDR 8'h0C

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define STG_TX_EN_BIT 2
`define STG_RX_EN_BIT 1
`define STG_LEARN_DIS_BIT 0
`define STG_TAIL_TAG_EN_BIT 1
`define STG_TAG_NORMAL_BIT 7
`define STG_CTRL_RESET 3'h6
`define STG_TAIL_TAG_RESET 1'h0

// ----------------------------------------------------------------------------
// Sizes and encodings
// ----------------------------------------------------------------------------
`define STG_NUM_PORTS 4
`define STG_HOST_SRC 3'h5
`define STG_WORD_WIDTH 9
`define STG_FIFO_DEPTH 32

`endif

// File: stg_pkg.sv
// Types shared by the spanning tree port gate.
package stg_pkg;

  typedef enum logic [3:0] {
    STG_ST_DISCARD = 4'h1,
    STG_ST_LEARN = 4'h2,
    STG_ST_FORWARD = 4'h4,
    STG_ST_OTHER = 4'h8
  } stg_stp_state_type;

endpackage

// File: stg_fifo.sv
// Descriptor FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module stg_fifo import stg_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  // DEPTH must be a power of two so the pointers wrap by themselves.
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + (AW+1)'(1);
    end else if (pop && !push) begin
      count <= count - (AW+1)'(1);
    end
  end

  fifo_no_overflow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    count == (AW+1)'(DEPTH) |-> !in_ready_out)
    else $error("FIFO accepted a word while full.");

endmodule

// File: stg_port_gate.sv
// Spanning tree port state gate: control registers, frame descriptor gating and output FIFO.
//
// How it works
// - Port 5 is the host port; it never takes a spanning tree state.
// - Ports 1 to 4 each hold transmit, receive and learning-disable bits at 0x12..0x42.
// - Five spanning tree states are selected only by the three control bits.
// - Disable: no normal forwarding or reception, no source address learning.
// - Disable still delivers override-matched frames to the host port.
// - Blocking forwards only frames destined to the processor; learning stays off.
// - Listening passes frames only to and from the processor, learning off.
// - Learning state exchanges frames only with processor and learns source addresses.
// - Forwarding state forwards and receives all traffic and learns.
// - Override-matched frames always reach the processor whatever the port state.
// - Host may inject tail-tagged frames toward a port; the switch delivers them.
// - Tail tagging acts only when enabled; tag bits 3:0 pick destination ports unless tag bit 7 is set.
`timescale 1ns/1ns
`include "stg_params.svh"
module stg_port_gate import stg_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [2:0] in_src_in,
  input wire logic [4:0] in_lookup_in,
  input wire logic in_override_in,
  input wire logic [7:0] in_tag_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [2:0] out_src_out,
  output logic [4:0] out_mask_out,
  output logic out_learn_out,
  output logic [15:0] port_state_out,
  output logic tail_tag_en_out
);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  localparam logic [7:0] PORT_ADDR [`STG_NUM_PORTS] = '{
    `STG_PORT1_CTRL_ADDR, `STG_PORT2_CTRL_ADDR, `STG_PORT3_CTRL_ADDR, `STG_PORT4_CTRL_ADDR};

  logic [2:0] port_ctrl [`STG_NUM_PORTS];
  logic [3:0] tx_en;
  logic [3:0] rx_en;
  logic [3:0] learn_dis;
  logic tail_tag_en;

  function automatic stg_stp_state_type decode_state(input logic [2:0] ctrl);
    stg_stp_state_type st;
    st = STG_ST_OTHER;
    // Disable, blocking and listening share one code, so they decode alike.
    case (ctrl)
      3'h1: st = STG_ST_DISCARD;
      3'h0: st = STG_ST_LEARN;
      3'h6: st = STG_ST_FORWARD;
      default: st = STG_ST_OTHER;
    endcase
    return st;
  endfunction

  for (genvar g = 0; g < `STG_NUM_PORTS; g++) begin : g_port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        port_ctrl[g] <= `STG_CTRL_RESET;
      end else if (reg_wr_in && reg_addr_in == PORT_ADDR[g]) begin
        port_ctrl[g] <= reg_wdata_in[2:0];
      end
    end

    assign tx_en[g] = port_ctrl[g][`STG_TX_EN_BIT];
    assign rx_en[g] = port_ctrl[g][`STG_RX_EN_BIT];
    assign learn_dis[g] = port_ctrl[g][`STG_LEARN_DIS_BIT];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        port_state_out[4*g +: 4] <= STG_ST_FORWARD;
      end else begin
        port_state_out[4*g +: 4] <= decode_state(port_ctrl[g]);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tail_tag_en <= `STG_TAIL_TAG_RESET;
    end else if (reg_wr_in && reg_addr_in == `STG_GLOBAL_CTRL_ADDR) begin
      tail_tag_en <= reg_wdata_in[`STG_TAIL_TAG_EN_BIT];
    end
  end

  assign tail_tag_en_out = tail_tag_en;

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `STG_PORT1_CTRL_ADDR: reg_rdata_out <= {5'h00, port_ctrl[0]};
        `STG_PORT2_CTRL_ADDR: reg_rdata_out <= {5'h00, port_ctrl[1]};
        `STG_PORT3_CTRL_ADDR: reg_rdata_out <= {5'h00, port_ctrl[2]};
        `STG_PORT4_CTRL_ADDR: reg_rdata_out <= {5'h00, port_ctrl[3]};
        `STG_GLOBAL_CTRL_ADDR: reg_rdata_out <= {6'h00, tail_tag_en, 1'h0};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Descriptor gating
  // --------------------------------------------------------------------------
  logic [4:0] next_mask;
  logic next_learn;
  logic [1:0] src_idx;
  logic src_is_port;
  logic src_is_host;
  logic tag_direct;

  assign src_is_port = (in_src_in >= 3'h1) && (in_src_in <= 3'h4);
  assign src_is_host = (in_src_in == `STG_HOST_SRC);
  assign src_idx = 2'(in_src_in - 3'h1);
  // A tag with its top bit set asks for the normal address lookup instead.
  assign tag_direct = tail_tag_en && !in_tag_in[`STG_TAG_NORMAL_BIT];

  always_comb begin
    next_mask = 5'h00;
    next_learn = 1'b0;
    if (src_is_port) begin
      if (rx_en[src_idx]) begin
        // The host port is never gated; the source port never reflects its own frame.
        next_mask = in_lookup_in & {1'b1, tx_en} & ~(5'(5'h01 << src_idx));
      end
      if (in_override_in) begin
        next_mask[4] = 1'b1;
      end
      next_learn = !learn_dis[src_idx];
    end else if (src_is_host) begin
      if (tag_direct) begin
        // Injected frames bypass transmit enable so the processor can reach a non-forwarding port.
        next_mask = {1'b0, in_tag_in[3:0]};
      end else begin
        next_mask = {1'b0, in_lookup_in[3:0] & tx_en};
      end
      next_learn = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Output FIFO
  // --------------------------------------------------------------------------
  logic [`STG_WORD_WIDTH-1:0] fifo_out_word;

  stg_fifo #(
    .WIDTH(`STG_WORD_WIDTH),
    .DEPTH(`STG_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(in_valid_in),
    .in_ready_out(in_ready_out),
    .in_data_in({in_src_in, next_learn, next_mask}),
    .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in),
    .out_data_out(fifo_out_word)
  );

  assign out_src_out = fifo_out_word[8:6];
  assign out_learn_out = fifo_out_word[5];
  assign out_mask_out = fifo_out_word[4:0];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  disabled_rx_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && !rx_en[src_idx] && !in_override_in |-> next_mask == 5'h00)
    else $error("Port with receive disabled forwarded a frame.");

  override_to_host_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && in_override_in |-> next_mask[4])
    else $error("Override-matched frame missed the host port.");

  blocked_host_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && !rx_en[src_idx] |-> next_mask[3:0] == 4'h0)
    else $error("Blocked port forwarded to a network port.");

  learn_follows_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port |-> next_learn == !learn_dis[src_idx])
    else $error("Learning does not follow the learning-disable bit.");

  tx_gate_egress_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && !(src_is_host && tag_direct) |-> (next_mask[3:0] & ~tx_en) == 4'h0)
    else $error("Frame sent to a port whose transmit is disabled.");

  tag_direct_dest_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_host && tag_direct |-> next_mask == {1'b0, in_tag_in[3:0]})
    else $error("Tail-tagged frame not sent to its tagged ports.");

  tag_off_lookup_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_host && !tail_tag_en |-> next_mask == {1'b0, in_lookup_in[3:0] & tx_en})
    else $error("Tail tag honoured while tail tagging is off.");

  ctrl_write_take_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == `STG_PORT2_CTRL_ADDR |=> port_ctrl[1] == $past(reg_wdata_in[2:0]))
    else $error("Port 2 control write not taken.");

  state_report_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    port_ctrl[0] == 3'h1 ##1 port_ctrl[0] == 3'h1 |-> port_state_out[3:0] == STG_ST_DISCARD)
    else $error("Port 1 discard state not reported.");

  host_word_order_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && in_ready_out && !out_valid_out |=> out_valid_out && out_src_out == $past(in_src_in))
    else $error("Descriptor did not reach the output in order.");

  // --------------------------------------------------------------------------
  // Checks on per-state and per-source gating
  // --------------------------------------------------------------------------
  // The control codes are spelled out here instead of going through the decoder.
  // A slip in the gating then shows up against the plain codes; the decoder is not exercised here.
  discard_no_learn_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && port_ctrl[src_idx] == 3'h1
    |-> !next_learn)
    else $error("Port in discard code learned a source address.");

  discard_override_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && port_ctrl[src_idx] == 3'h1
    |-> next_mask == {in_override_in, 4'h0})
    else $error("Port in discard code passed more than override frames.");

  learn_state_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && port_ctrl[src_idx] == 3'h0
    |-> next_learn && next_mask[3:0] == 4'h0)
    else $error("Learning port forwarded to the network or did not learn.");

  forward_state_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port && port_ctrl[src_idx] == 3'h6
    |-> next_learn && next_mask[4] == (in_lookup_in[4] || in_override_in))
    else $error("Forwarding port lost learning or host delivery.");

  no_self_reflect_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_port
    |-> !next_mask[src_idx])
    else $error("Frame sent back to its own source port.");

  host_not_looped_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_host
    |-> !next_mask[4] && next_learn)
    else $error("Host frame looped back to the host port.");

  stray_src_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && !src_is_port && !src_is_host
    |-> next_mask == 5'h00 && !next_learn)
    else $error("Descriptor from an unknown source was forwarded.");

  tag_normal_lookup_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_host && tail_tag_en && in_tag_in[`STG_TAG_NORMAL_BIT]
    |-> next_mask == {1'b0, in_lookup_in[3:0] & tx_en})
    else $error("Tail tag with lookup bit set did not use the lookup.");

  listen_inject_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    in_valid_in && src_is_host && tag_direct
    |-> (next_mask[3:0] & ~tx_en) == (in_tag_in[3:0] & ~tx_en))
    else $error("Injected frame did not reach a port with transmit off.");

  // --------------------------------------------------------------------------
  // Checks on registers, reported state and the stalled output
  // --------------------------------------------------------------------------
  forward_report_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    port_ctrl[2] == 3'h6 ##1 port_ctrl[2] == 3'h6
    |-> port_state_out[11:8] == STG_ST_FORWARD)
    else $error("Port 3 forwarding state not reported.");

  learn_report_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    port_ctrl[3] == 3'h0 ##1 port_ctrl[3] == 3'h0
    |-> port_state_out[15:12] == STG_ST_LEARN)
    else $error("Port 4 learning state not reported.");

  other_report_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    port_ctrl[1] == 3'h7 ##1 port_ctrl[1] == 3'h7
    |-> port_state_out[7:4] == STG_ST_OTHER)
    else $error("Port 2 unlisted code not reported.");

  port1_read_back_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == `STG_PORT1_CTRL_ADDR
    |=> reg_rdata_out == {5'h00, $past(port_ctrl[0])})
    else $error("Port 1 control read back wrong.");

  tag_en_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == `STG_GLOBAL_CTRL_ADDR
    |=> tail_tag_en == $past(reg_wdata_in[`STG_TAIL_TAG_EN_BIT]))
    else $error("Tail tag enable write not taken.");

  tag_en_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == `STG_GLOBAL_CTRL_ADDR
    |=> reg_rdata_out == {6'h00, $past(tail_tag_en), 1'b0})
    else $error("Tail tag enable read back wrong.");

  out_word_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    out_valid_out && !out_ready_in
    |=> out_valid_out && $stable(out_mask_out) && $stable(out_src_out))
    else $error("Output descriptor changed while stalled.");

endmodule

// File: stg_host_model.sv
// Behavioural host processor that sinks frame descriptors on the switch host port.
`timescale 1ns/1ns
module stg_host_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [2:0] src_in,
  input wire logic [15:0] port_state_in,
  output logic ready_out,
  output logic [7:0] drop_count_out
);
  logic [3:0] src_state;

  assign ready_out = !stall_in;
  // The state is read at the pop, so software must not retune a port with its frames still queued.
  assign src_state = port_state_in[{src_in[1:0] - 2'h1, 2'h0} +: 4];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drop_count_out <= 8'h00;
    end else if (valid_in && ready_out && src_in >= 3'h1 && src_in <= 3'h4 && src_state == 4'h1) begin
      drop_count_out <= drop_count_out + 8'h01;
    end
  end
endmodule

// File: stg_tb.sv
// Self-checking testbench for the spanning tree port gate.
`timescale 1ns/1ns
`include "stg_params.svh"
module tb;
  logic clk_in, rst_n_in, reg_wr, reg_rd, in_valid, in_ovr, stall, out_valid, in_ready, out_ready, out_learn, tt_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, in_tag, drops;
  logic [2:0] in_src, out_src;
  logic [4:0] in_lookup, out_mask;
  logic [15:0] pstate;
  logic [2:0] ctrl [1:4];
  logic tt;
  logic [8:0] expq [$];
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  logic [3:0] sexp [4] = '{4'h2, 4'h1, 4'h4, 4'h8};
  int bad_count, checks;

  stg_port_gate stg_port_gate_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .in_valid_in(in_valid),
    .in_ready_out(in_ready), .in_src_in(in_src), .in_lookup_in(in_lookup), .in_override_in(in_ovr),
    .in_tag_in(in_tag), .out_valid_out(out_valid), .out_ready_in(out_ready), .out_src_out(out_src),
    .out_mask_out(out_mask), .out_learn_out(out_learn), .port_state_out(pstate), .tail_tag_en_out(tt_en));
  stg_host_model stg_host_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall), .valid_in(out_valid),
    .src_in(out_src), .port_state_in(pstate), .ready_out(out_ready), .drop_count_out(drops));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic fail(input string msg);
    bad_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask

  task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("descriptor %h expected %h", got, exp));
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk_val({8'h00, reg_rdata}, {8'h00, exp});
    tick;
  endtask

  task automatic setp(input int p, input logic [2:0] c);
    wr(8'h02 + 8'(p * 16), {5'h1F, c});
    ctrl[p] = c;
  endtask

  // Expected descriptor worked out from the shadow copy of the controls.
  function automatic logic [8:0] expw(input logic [2:0] s, input logic [4:0] lk, input logic ov, input logic [7:0] tg);
    logic [4:0] m;
    logic l;
    logic [3:0] txv;
    txv = {ctrl[4][2], ctrl[3][2], ctrl[2][2], ctrl[1][2]};
    m = 5'h00;
    l = 1'b0;
    if (s >= 3'h1 && s <= 3'h4) begin
      if (ctrl[s][1]) m = lk & {1'b1, txv} & ~(5'h01 << (s - 3'h1));
      if (ov) m[4] = 1'b1;
      l = !ctrl[s][0];
    end else if (s == 3'h5) begin
      l = 1'b1;
      m = (tt && !tg[7]) ? {1'b0, tg[3:0]} : {1'b0, lk[3:0] & txv};
    end
    return {s, l, m};
  endfunction

  // Valid stays high between sends so back-to-back pushes never toggle it in one time step.
  task automatic send(input logic [2:0] s, input logic [4:0] lk, input logic ov, input logic [7:0] tg);
    int n;
    {in_src, in_lookup, in_ovr, in_tag} = {s, lk, ov, tg};
    in_valid = 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (in_ready === 1'b1) break;
    end
    if (n == 100) fail("descriptor never taken");
    expq.push_back(expw(s, lk, ov, tg));
    #1;
  endtask

  task automatic drain;
    in_valid = 1'b0;
    for (int n = 0; n < 200 && (expq.size() != 0 || out_valid !== 1'b0); n++) tick;
  endtask

  always @(posedge clk_in) begin
    if (rst_n_in && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) fail("unexpected descriptor");
      else chk_word({out_src, out_learn, out_mask}, expq.pop_front());
    end
  end

  initial begin
    #(40 * 4000);
    fail("watchdog expired");
    results;
  end

  initial begin
    {rst_n_in, reg_wr, reg_rd, in_valid, in_ovr, stall, tt} = 7'h00;
    {reg_addr, reg_wdata, in_tag, in_src, in_lookup} = '0;
    for (int p = 1; p <= 4; p++) ctrl[p] = 3'h6;
    repeat (3) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    chk_val(pstate, 16'h4444);
    chk_val({15'h0, tt_en}, 16'h0000);
    for (int p = 1; p <= 4; p++) rd(8'h02 + 8'(p * 16), 8'h06);
    rd(8'h13, 8'h00);
    for (int p = 1; p <= 4; p++) begin
      for (int k = 0; k < 4; k++) begin
        setp(p, codes[k]);
        tick;
        chk_val({12'h0, pstate[4 * (p - 1) +: 4]}, {12'h0, sexp[k]});
        rd(8'h02 + 8'(p * 16), {5'h00, codes[k]});
      end
      setp(p, 3'h6);
    end
    setp(3, 3'h2);
    send(3'h1, 5'h1F, 1'b0, 8'h00);
    send(3'h5, 5'h1F, 1'b0, 8'h00);
    drain;
    setp(1, 3'h1);
    send(3'h1, 5'h1F, 1'b0, 8'h00);
    send(3'h1, 5'h1F, 1'b1, 8'h00);
    drain;
    chk_val({8'h00, drops}, 16'h0002);
    setp(1, 3'h0);
    send(3'h1, 5'h1F, 1'b0, 8'h00);
    send(3'h1, 5'h1F, 1'b1, 8'h00);
    drain;
    wr(`STG_GLOBAL_CTRL_ADDR, 8'hFF);
    tt = 1'b1;
    rd(`STG_GLOBAL_CTRL_ADDR, 8'h02);
    chk_val({15'h0, tt_en}, 16'h0001);
    send(3'h5, 5'h00, 1'b0, 8'h01);
    send(3'h5, 5'h0F, 1'b0, 8'h8F);
    send(3'h5, 5'h00, 1'b0, 8'h7F);
    send(3'h6, 5'h1F, 1'b1, 8'h00);
    drain;
    setp(1, 3'h6);
    stall = 1'b1;
    for (int i = 0; i < 32; i++) send(3'h1, 5'(i), 1'b0, 8'h00);
    in_valid = 1'b0;
    chk_val({15'h0, in_ready}, 16'h0000);
    stall = 1'b0;
    drain;
    chk_val({14'h0, out_valid, in_ready}, 16'h0001);
    results;
  end
endmodule
